//--- design/fbis_top.v
// Top of the function block core with its AXI4-Lite register slave.
// Assumes synchronous logic inputs from neighbouring blocks and one clock.
`timescale 1ns/100ps
`include "fbis_consts.vh"

module fbis_top #(
    parameter BASE_TICK_CYCLES = `FBIS_BASE_TICK_NS / `FBIS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // AXI4-Lite write address and data
    input wire i_awvalid,
    output reg o_awready,
    input wire [7:0] i_awaddr,
    input wire i_wvalid,
    output reg o_wready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    // AXI4-Lite write response
    output reg o_bvalid,
    input wire i_bready,
    output reg [1:0] o_bresp,
    // AXI4-Lite read
    input wire i_arvalid,
    output reg o_arready,
    input wire [7:0] i_araddr,
    output reg o_rvalid,
    input wire i_rready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    // Logical inputs of the special block
    input wire i_set,
    input wire i_reset,
    input wire i_trigger,
    input wire i_count,
    input wire i_direction,
    input wire i_enable,
    input wire i_invert,
    input wire i_reset_all,
    // Inverter block
    input wire i_not_in,
    output reg o_not_out,
    // Power restart and parameter mode
    input wire i_power_up,
    input wire i_param_mode,
    output reg o_param_visible,
    // Analog input and results
    input wire [13:0] i_analog_voltage_input,
    output wire [9:0] o_analog_internal,
    output wire [15:0] o_scaled_analog_value,
    // Block output
    output reg o_q
);
    reg [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];
    reg [5:0] ctrl_q;
    reg [7:0] invmask_q;
    reg [14:0] time_q;
    reg [15:0] gain_q;
    reg [15:0] offset_q;
    reg aw_full_q;
    reg w_full_q;
    reg [7:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg q_q;
    reg [15:0] count_q;
    reg [15:0] elapsed_q;
    reg trg_prev_q;
    reg cnt_prev_q;
    reg timing_q;
    reg inv_q;
    wire tick_base;
    wire tick_sec;
    wire tick_min;
    wire [`FBIS_NUM_IN-1:0] raw_in;
    wire [`FBIS_NUM_IN-1:0] in_eff;
    wire [1:0] mode = ctrl_q[`FBIS_CTRL_MODE_LSB +: 2];
    wire [1:0] tbase = ctrl_q[`FBIS_CTRL_TBASE_LSB +: 2];
    wire retain = ctrl_q[`FBIS_CTRL_RETAIN_BIT];
    wire locked = ctrl_q[`FBIS_CTRL_PROTECT_BIT] & i_param_mode;
    wire [15:0] target = time_total(tbase, time_q);
    wire [31:0] merged = merge_bytes(rd_word(waddr_q), wdata_q, wstrb_q);
    reg tick_sel;

    // Total time units from the two printed fields of a time value
    function [15:0] time_total;
        input [1:0] tb;
        input [14:0] t;
        begin
            if (tb == `FBIS_TB_SEC)
                time_total = {9'h0, t[14:8]} * 16'd100 + {9'h0, t[6:0]};
            else
                time_total = {9'h0, t[14:8]} * 16'd60 + {9'h0, t[6:0]};
        end
    endfunction

    // Byte-lane merge of write data into the current register word
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            merge_bytes = old;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    merge_bytes[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    // Register read decode, shared by reads and byte merges
    function [31:0] rd_word;
        input [7:0] a;
        begin
            case (a)
                `FBIS_OFS_CTRL: rd_word = {26'h0, ctrl_q};
                `FBIS_OFS_INVMASK: rd_word = {24'h0, invmask_q};
                `FBIS_OFS_TIME: rd_word = {17'h0, time_q};
                `FBIS_OFS_GAIN: rd_word = {16'h0, gain_q};
                `FBIS_OFS_OFFSET: rd_word = {16'h0, offset_q};
                `FBIS_OFS_STATUS: rd_word = {29'h0, timing_q, o_not_out, q_q};
                `FBIS_OFS_COUNT: rd_word = {16'h0, count_q};
                `FBIS_OFS_ELAPSED: rd_word = {16'h0, elapsed_q};
                `FBIS_OFS_ANALOG: rd_word = {o_scaled_analog_value, 6'h0, o_analog_internal};
                default: rd_word = 32'h0;
            endcase
        end
    endfunction

    // Addresses that answer OKAY
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a <= `FBIS_OFS_ANALOG) && (a[1:0] == 2'h0);
        end
    endfunction

    // Clamp a signed 16-bit value to a symmetric limit
    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lim;
        begin
            if ($signed(v) > $signed(lim))
                clamp16 = lim;
            else if ($signed(v) < -$signed(lim))
                clamp16 = -lim;
            else
                clamp16 = v;
        end
    endfunction

    // Reset release through two flip-flops
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    fbis_timebase #(
        .BASE_TICK_CYCLES(BASE_TICK_CYCLES)
    ) u_timebase (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .o_tick_base(tick_base),
        .o_tick_sec(tick_sec),
        .o_tick_min(tick_min)
    );

    fbis_analog_scaler u_scaler (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_millivolts(i_analog_voltage_input),
        .i_gain(gain_q),
        .i_offset(offset_q),
        .o_internal(o_analog_internal),
        .o_scaled(o_scaled_analog_value)
    );

    always @* begin
        case (tbase)
            `FBIS_TB_SEC: tick_sel = tick_base;
            `FBIS_TB_MIN: tick_sel = tick_sec;
            `FBIS_TB_HOUR: tick_sel = tick_min;
            default: tick_sel = tick_base;
        endcase
    end

    assign raw_in = {i_reset_all, i_invert, i_enable, i_direction,
                     i_count, i_trigger, i_reset, i_set};
    genvar g;
    generate
        for (g = 0; g < `FBIS_NUM_IN; g = g + 1) begin : g_inv
            assign in_eff[g] = raw_in[g] ^ invmask_q[g];
        end
    endgenerate

    // AXI4-Lite slave: address and data taken in either order
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `FBIS_RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= `FBIS_RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            waddr_q <= 8'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            ctrl_q <= `FBIS_CTRL_RST;
            invmask_q <= `FBIS_INVMASK_RST;
            time_q <= `FBIS_TIME_RST;
            gain_q <= `FBIS_GAIN_RST;
            offset_q <= `FBIS_OFFSET_RST;
        end else begin
            o_awready <= !aw_full_q && !(i_awvalid && o_awready) && !o_bvalid;
            o_wready <= !w_full_q && !(i_wvalid && o_wready) && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_full_q <= 1'b1;
                waddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (aw_full_q && w_full_q && !o_bvalid) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= is_mapped(waddr_q) ? `FBIS_RESP_OKAY : `FBIS_RESP_SLVERR;
                case (waddr_q)
                    `FBIS_OFS_CTRL: ctrl_q <= merged[5:0];
                    `FBIS_OFS_INVMASK: invmask_q <= merged[7:0];
                    `FBIS_OFS_TIME: if (!locked) time_q <= merged[14:0];
                    `FBIS_OFS_GAIN: if (!locked) gain_q <= clamp16(merged[15:0], 16'd1000);
                    `FBIS_OFS_OFFSET: if (!locked) offset_q <= clamp16(merged[15:0], 16'd10000);
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_word(i_araddr);
                o_rresp <= is_mapped(i_araddr) ? `FBIS_RESP_OKAY : `FBIS_RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Special block state, evaluated once per scan cycle
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= 1'b0;
            count_q <= 16'h0;
            elapsed_q <= 16'h0;
            timing_q <= 1'b0;
            trg_prev_q <= 1'b0;
            cnt_prev_q <= 1'b0;
        end else if (i_power_up) begin
            if (!retain) begin
                q_q <= 1'b0;
                count_q <= 16'h0;
                elapsed_q <= 16'h0;
                timing_q <= 1'b0;
            end
        end else if (in_eff[`FBIS_IN_RALL]) begin
            q_q <= 1'b0;
            count_q <= 16'h0;
            elapsed_q <= 16'h0;
            timing_q <= 1'b0;
        end else if (!in_eff[`FBIS_IN_EN]) begin
            q_q <= q_q;
        end else if (in_eff[`FBIS_IN_RESET]) begin
            q_q <= 1'b0;
            elapsed_q <= 16'h0;
            timing_q <= 1'b0;
            trg_prev_q <= in_eff[`FBIS_IN_TRG];
            cnt_prev_q <= in_eff[`FBIS_IN_CNT];
        end else begin
            trg_prev_q <= in_eff[`FBIS_IN_TRG];
            cnt_prev_q <= in_eff[`FBIS_IN_CNT];
            case (mode)
                `FBIS_MODE_ONDELAY: begin
                    if (!in_eff[`FBIS_IN_TRG]) begin
                        timing_q <= 1'b0;
                        elapsed_q <= 16'h0;
                        q_q <= in_eff[`FBIS_IN_SET];
                    end else if (!trg_prev_q) begin
                        timing_q <= 1'b1;
                        elapsed_q <= 16'h0;
                    end else if (timing_q && elapsed_q >= target) begin
                        timing_q <= 1'b0;
                        q_q <= 1'b1;
                    end else if (timing_q && tick_sel) begin
                        elapsed_q <= elapsed_q + 16'h1;
                    end
                end
                `FBIS_MODE_COUNTER: begin
                    if (in_eff[`FBIS_IN_CNT] && !cnt_prev_q) begin
                        if (in_eff[`FBIS_IN_DIR])
                            count_q <= count_q - 16'h1;
                        else
                            count_q <= count_q + 16'h1;
                    end
                    q_q <= in_eff[`FBIS_IN_SET] || (count_q >= target);
                end
                default: begin
                    if (in_eff[`FBIS_IN_SET])
                        q_q <= 1'b1;
                end
            endcase
        end
    end

    // Registered outputs
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_q <= 1'b0;
            o_not_out <= 1'b1;
            o_param_visible <= 1'b1;
            inv_q <= 1'b0;
        end else begin
            if (in_eff[`FBIS_IN_EN])
                inv_q <= in_eff[`FBIS_IN_INV];
            o_q <= q_q ^ inv_q;
            o_not_out <= ~i_not_in;
            o_param_visible <= !(ctrl_q[`FBIS_CTRL_PROTECT_BIT] && i_param_mode);
        end
    end
endmodule

//--- design/fbis_consts.vh
// Constants for the function block core: register map, fields, resets, timing.
// Assumes inclusion by every design file of the block; definitions only.
`ifndef FBIS_CONSTS_VH
`define FBIS_CONSTS_VH

// Register byte offsets
`define FBIS_OFS_CTRL 8'h00
`define FBIS_OFS_INVMASK 8'h04
`define FBIS_OFS_TIME 8'h08
`define FBIS_OFS_GAIN 8'h0c
`define FBIS_OFS_OFFSET 8'h10
`define FBIS_OFS_STATUS 8'h14
`define FBIS_OFS_COUNT 8'h18
`define FBIS_OFS_ELAPSED 8'h1c
`define FBIS_OFS_ANALOG 8'h20

// Control field positions
`define FBIS_CTRL_MODE_LSB 0
`define FBIS_CTRL_TBASE_LSB 2
`define FBIS_CTRL_RETAIN_BIT 4
`define FBIS_CTRL_PROTECT_BIT 5

// Block modes
`define FBIS_MODE_LATCH 2'h0
`define FBIS_MODE_ONDELAY 2'h1
`define FBIS_MODE_COUNTER 2'h2

// Timebases
`define FBIS_TB_SEC 2'h0
`define FBIS_TB_MIN 2'h1
`define FBIS_TB_HOUR 2'h2

// Logical input positions in the inversion mask
`define FBIS_IN_SET 0
`define FBIS_IN_RESET 1
`define FBIS_IN_TRG 2
`define FBIS_IN_CNT 3
`define FBIS_IN_DIR 4
`define FBIS_IN_EN 5
`define FBIS_IN_INV 6
`define FBIS_IN_RALL 7
`define FBIS_NUM_IN 8

// Reset values
`define FBIS_CTRL_RST 6'h00
`define FBIS_INVMASK_RST 8'h00
`define FBIS_TIME_RST 15'h0000
`define FBIS_GAIN_RST 16'h0064
`define FBIS_OFFSET_RST 16'h0000

// Analog limits
`define FBIS_AI_MAX 1000
`define FBIS_AI_MV_PER_LSB 10
`define FBIS_GAIN_MAX 1000
`define FBIS_OFFSET_MAX 10000
`define FBIS_GAIN_DIV 100

// Timing: clock period and base tick (10 ms), both in ns
`define FBIS_CLK_PERIOD_NS 40
`define FBIS_BASE_TICK_NS 10000000
`define FBIS_TICKS_PER_SEC 100
`define FBIS_SEC_PER_MIN 60

// Bus responses
`define FBIS_RESP_OKAY 2'h0
`define FBIS_RESP_SLVERR 2'h2

`endif

//--- design/fbis_timebase.v
// Timebase divider: 10 ms, 1 s and 1 min enable pulses from the system clock.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/100ps
`include "fbis_consts.vh"

module fbis_timebase #(
    parameter BASE_TICK_CYCLES = 250000
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Tick pulses
    output reg o_tick_base,
    output reg o_tick_sec,
    output reg o_tick_min
);
    reg [31:0] div_q;
    reg [6:0] hund_q;
    reg [5:0] sec_q;

    // Cascaded dividers, each stage steps on the pulse of the one below
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= 32'h0;
            hund_q <= 7'h0;
            sec_q <= 6'h0;
            o_tick_base <= 1'b0;
            o_tick_sec <= 1'b0;
            o_tick_min <= 1'b0;
        end else begin
            o_tick_base <= 1'b0;
            o_tick_sec <= 1'b0;
            o_tick_min <= 1'b0;
            if (div_q == BASE_TICK_CYCLES - 1) begin
                div_q <= 32'h0;
                o_tick_base <= 1'b1;
                if (hund_q == `FBIS_TICKS_PER_SEC - 1) begin
                    hund_q <= 7'h0;
                    o_tick_sec <= 1'b1;
                    if (sec_q == `FBIS_SEC_PER_MIN - 1) begin
                        sec_q <= 6'h0;
                        o_tick_min <= 1'b1;
                    end else begin
                        sec_q <= sec_q + 6'h1;
                    end
                end else begin
                    hund_q <= hund_q + 7'h1;
                end
            end else begin
                div_q <= div_q + 32'h1;
            end
        end
    end
endmodule

//--- design/fbis_analog_scaler.v
// Analog path: millivolt input to 0..1000 internal value, then gain and offset.
// Assumes the input is a synchronous millivolt code and gain is in hundredths.
`timescale 1ns/100ps
`include "fbis_consts.vh"

module fbis_analog_scaler (
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Input code and scaling settings
    input wire [13:0] i_millivolts,
    input wire signed [15:0] i_gain,
    input wire signed [15:0] i_offset,
    // Results
    output reg [9:0] o_internal,
    output reg signed [15:0] o_scaled
);
    wire [31:0] steps = i_millivolts / `FBIS_AI_MV_PER_LSB;
    wire signed [26:0] product = $signed({1'b0, o_internal}) * i_gain;
    wire signed [31:0] whole = product / `FBIS_GAIN_DIV;
    wire signed [31:0] total = whole + i_offset;

    // Stage one converts and clips, stage two scales
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_internal <= 10'h0;
            o_scaled <= 16'h0;
        end else begin
            if (steps > `FBIS_AI_MAX)
                o_internal <= 10'd1000;
            else
                o_internal <= steps[9:0];
            o_scaled <= total[15:0];
        end
    end
endmodule

//--- verif/fbis_top_assertions.sv
// Checker for the function block core: timing relations seen at its ports.
// Assumes it is bound to fbis_top and that inputs sit low while in reset.
`timescale 1ns/100ps

module fbis_top_checker #(
    parameter BASE_TICK_CYCLES = 4
) (
    // Clock and reset
    input wire i_clock,
    input wire i_reset_n,
    // Inverter
    input wire i_not_in,
    input wire o_not_out,
    // Block logic
    input wire i_reset,
    input wire i_enable,
    input wire i_invert,
    input wire i_power_up,
    input wire i_reset_all,
    input wire o_q,
    // Parameter mode
    input wire i_param_mode,
    input wire o_param_visible,
    // Analog
    input wire [13:0] i_analog_voltage_input,
    input wire [9:0] o_analog_internal,
    // Bus answers
    input wire o_bvalid,
    input wire i_bready,
    input wire [1:0] o_bresp,
    input wire o_rvalid,
    input wire i_rready,
    input wire [31:0] o_rdata
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    // Clearing request held over two scans with invert quiet
    sequence s_clear(logic c);
        (c && !i_invert && !i_power_up)[*2];
    endsequence
    // Enable low with nothing of higher priority, three scans long
    sequence s_frozen;
        (!i_enable && !i_power_up && !i_reset_all)[*3];
    endsequence

    a_not_inverts: assert property (o_not_out == !$past(i_not_in))
        else $error("inverter output is not the complement of its input");
    a_reset_clears: assert property (s_clear(i_reset && i_enable) |=> !o_q)
        else $error("block output not cleared by reset");
    a_reset_all_clears: assert property (s_clear(i_reset_all) |=> !o_q)
        else $error("block output not cleared by reset-all");
    a_enable_hold: assert property (s_frozen |=> $stable(o_q))
        else $error("block output moved while enable was low");
    a_param_shown: assert property (!$past(i_param_mode) |-> o_param_visible)
        else $error("parameters hidden outside parameter mode");
    a_analog_sat: assert property ($past(i_analog_voltage_input) >= 14'd10000 |->
        o_analog_internal == 10'd1000)
        else $error("analog internal value not saturated");
    a_analog_lin: assert property ($past(i_analog_voltage_input) < 14'd10000 |->
        o_analog_internal == 10'($past(i_analog_voltage_input) / 14'd10))
        else $error("analog internal value not linear in the input");
    // Write response stands until taken
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before bready");
    // Read data stands until taken
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before rready");
endmodule

bind fbis_top fbis_top_checker #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) u_checker (
    .i_clock, .i_reset_n, .i_not_in, .o_not_out, .i_reset, .i_enable, .i_invert,
    .i_power_up, .i_reset_all, .o_q, .i_param_mode, .o_param_visible,
    .i_analog_voltage_input, .o_analog_internal, .o_bvalid, .i_bready, .o_bresp,
    .o_rvalid, .i_rready, .o_rdata
);

//--- verif/fbis_pulse_peer.sv
// Neighbouring block model: sends a burst of count pulses on request.
// Assumes requests come only while idle; pulses are two cycles high, two low.
`timescale 1ns/100ps

module fbis_pulse_peer (
    // Clock
    input wire i_clock,
    // Request
    input wire i_go,
    input wire [3:0] i_num,
    // Pulse line and state
    output wire o_pulse,
    output wire o_busy
);
    reg [5:0] left_q = 6'h00;

    // Four cycles per pulse, counted down
    always @(posedge i_clock) begin
        if (i_go && left_q == 6'h00) begin
            left_q <= {i_num, 2'b00};
        end else if (left_q != 6'h00) begin
            left_q <= left_q - 6'h01;
        end
    end
    assign o_pulse = left_q[1];
    assign o_busy = (left_q != 6'h00);
endmodule

//--- verif/function_block_inputs_scaling_bench.sv
// Self-checking bench for the function block core and its register slave.
// Assumes the design, the checker and the pulse peer are compiled before it.
`timescale 1ns/100ps
`include "fbis_consts.vh"

module function_block_inputs_scaling_bench;
    logic i_clock, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0] i_wstrb, peer_num;
    logic i_set, i_reset, i_trigger, i_direction, i_enable, i_invert, i_reset_all;
    logic i_not_in, i_power_up, i_param_mode, peer_go;
    logic [13:0] i_analog_voltage_input;
    wire i_count, peer_busy, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire o_not_out, o_param_visible, o_q;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [9:0] o_analog_internal;
    wire [15:0] o_scaled_analog_value;
    int n_errors = 0;
    int num_checks = 0;
    // Millivolts, gain, offset, internal, scaled, inverter in, inverter out
    logic [15:0] rows [11][7] = '{'{0, 10, -30, 0, -30, 0, 1}, '{3000, 10, -30, 300, 0, 1, 0},
        '{10000, 10, -30, 1000, 70, 0, 1}, '{6750, 400, 1000, 675, 3700, 1, 0},
        '{12000, 1000, -10000, 1000, 0, 0, 1}, '{20, 1, 0, 2, 0, 1, 0},
        '{20, 1000, 0, 2, 20, 0, 1}, '{5000, -100, -200, 500, -700, 1, 0},
        '{50, -10, 0, 5, 0, 0, 1}, '{10000, 1500, -12000, 1000, 0, 1, 0},
        '{9990, 100, 0, 999, 999, 0, 1}};
    // Control, time, cycles still off, further cycles until on
    int odly [3][4] = '{'{1, 3, 6, 14}, '{1, 16'h0101, 390, 40}, '{5, 2, 350, 550}};

    fbis_top #(.BASE_TICK_CYCLES(4)) DUT (
        .i_clock, .i_reset_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
        .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_set, .i_reset,
        .i_trigger, .i_count, .i_direction, .i_enable, .i_invert, .i_reset_all,
        .i_not_in, .o_not_out, .i_power_up, .i_param_mode, .o_param_visible,
        .i_analog_voltage_input, .o_analog_internal, .o_scaled_analog_value, .o_q);
    fbis_pulse_peer u_peer (.i_clock, .i_go(peer_go), .i_num(peer_num),
        .o_pulse(i_count), .o_busy(peer_busy));

    // Free-running clock
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic qis(input logic e);
        check("q", 32'(e), 32'(o_q));
    endtask

    // Bus write; bready raised late so the response must stand
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k = 0;
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        do begin
            @(posedge i_clock);
            k++;
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (k == 4) i_bready <= 1'b1;
        end while (!(o_bvalid && i_bready));
        check("bresp", 32'(er), 32'(o_bresp));
        i_bready <= 1'b0;
    endtask

    // Bus read; rready raised late so the data must stand
    task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        int k = 0;
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do begin
            @(posedge i_clock);
            k++;
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (k == 2) i_rready <= 1'b1;
        end while (!(o_rvalid && i_rready));
        check("rresp", 32'(er), 32'(o_rresp));
        check("rdata", ed, o_rdata);
        i_rready <= 1'b0;
    endtask

    task automatic burst(input logic [3:0] n);
        @(posedge i_clock);
        peer_num <= n;
        peer_go <= 1'b1;
        @(posedge i_clock);
        peer_go <= 1'b0;
        do @(posedge i_clock); while (peer_busy);
        cyc(3);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        cyc(20000);
        n_errors++;
        summarize();
    end

    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
        {i_set, i_reset, i_trigger, i_direction, i_invert, i_reset_all, peer_num} = '0;
        {i_not_in, i_power_up, i_param_mode, peer_go, i_analog_voltage_input} = '0;
        i_wstrb = 4'hf;
        i_enable = 1'b1;
        i_reset_n = 1'b0;
        cyc(2);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            axw(`FBIS_OFS_GAIN, {{16{rows[i][1][15]}}, rows[i][1]}, `FBIS_RESP_OKAY);
            axw(`FBIS_OFS_OFFSET, {{16{rows[i][2][15]}}, rows[i][2]}, `FBIS_RESP_OKAY);
            i_analog_voltage_input <= rows[i][0][13:0];
            i_not_in <= rows[i][5][0];
            cyc(4);
            check("internal", 32'(rows[i][3]), 32'(o_analog_internal));
            check("scaled", 32'(rows[i][4]), 32'(o_scaled_analog_value));
            check("not_out", 32'(rows[i][6]), 32'(o_not_out));
        end
        // Second reset mid-run, then reset values and an unmapped place
        i_analog_voltage_input <= '0;
        i_not_in <= 1'b0;
        cyc(2);
        i_reset_n <= 1'b0;
        cyc(2);
        check("not_out", 32'h1, 32'(o_not_out));
        i_reset_n <= 1'b1;
        axr(`FBIS_OFS_GAIN, `FBIS_RESP_OKAY, 32'h64);
        axr(`FBIS_OFS_OFFSET, `FBIS_RESP_OKAY, 32'h0);
        axr(8'h24, `FBIS_RESP_SLVERR, 32'h0);
        i_set <= 1'b1;
        cyc(1);
        i_set <= 1'b0;
        cyc(3);
        qis(1'b1);
        i_set <= 1'b1;
        i_reset <= 1'b1;
        cyc(3);
        qis(1'b0);
        i_reset <= 1'b0;
        cyc(3);
        i_set <= 1'b0;
        i_enable <= 1'b0;
        i_reset <= 1'b1;
        i_invert <= 1'b1;
        cyc(4);
        qis(1'b1);
        i_reset <= 1'b0;
        i_enable <= 1'b1;
        cyc(3);
        qis(1'b0);
        i_invert <= 1'b0;
        cyc(3);
        qis(1'b1);
        i_reset_all <= 1'b1;
        cyc(2);
        i_reset_all <= 1'b0;
        cyc(3);
        qis(1'b0);
        axw(`FBIS_OFS_INVMASK, 32'h1, `FBIS_RESP_OKAY);
        cyc(3);
        qis(1'b1);
        i_reset <= 1'b1;
        cyc(3);
        qis(1'b0);
        axw(`FBIS_OFS_INVMASK, 32'h0, `FBIS_RESP_OKAY);
        i_reset <= 1'b0;
        axw(`FBIS_OFS_CTRL, 32'h12, `FBIS_RESP_OKAY);
        axw(`FBIS_OFS_TIME, 32'h3, `FBIS_RESP_OKAY);
        burst(4'h4);
        axr(`FBIS_OFS_COUNT, `FBIS_RESP_OKAY, 32'h4);
        qis(1'b1);
        i_direction <= 1'b1;
        burst(4'h2);
        axr(`FBIS_OFS_COUNT, `FBIS_RESP_OKAY, 32'h2);
        qis(1'b0);
        i_power_up <= 1'b1;
        cyc(1);
        i_power_up <= 1'b0;
        axr(`FBIS_OFS_COUNT, `FBIS_RESP_OKAY, 32'h2);
        i_reset_all <= 1'b1;
        cyc(1);
        i_reset_all <= 1'b0;
        axr(`FBIS_OFS_COUNT, `FBIS_RESP_OKAY, 32'h0);
        foreach (odly[i]) begin
            axw(`FBIS_OFS_CTRL, 32'(odly[i][0]), `FBIS_RESP_OKAY);
            axw(`FBIS_OFS_TIME, 32'(odly[i][1]), `FBIS_RESP_OKAY);
            i_trigger <= 1'b1;
            cyc(odly[i][2]);
            qis(1'b0);
            cyc(odly[i][3]);
            qis(1'b1);
            i_trigger <= 1'b0;
            cyc(3);
            qis(1'b0);
        end
        axw(`FBIS_OFS_CTRL, 32'h20, `FBIS_RESP_OKAY);
        axw(`FBIS_OFS_TIME, 32'h7, `FBIS_RESP_OKAY);
        i_param_mode <= 1'b1;
        cyc(3);
        check("visible", 32'h0, 32'(o_param_visible));
        axw(`FBIS_OFS_TIME, 32'h5, `FBIS_RESP_OKAY);
        axr(`FBIS_OFS_TIME, `FBIS_RESP_OKAY, 32'h7);
        i_param_mode <= 1'b0;
        cyc(3);
        check("visible", 32'h1, 32'(o_param_visible));
        summarize();
    end
endmodule
